//--- logic/acs_defines.svh
// Offsets, field positions, reset values and timing counts of the converter control block.
// Assumes a 10 MHz system clock and a word-wide AHB-Lite register bus.
// How it works
// R1 - The three-bit clock select picks sysclk/2, /8, /32, /4, /16, /64, or, for either x11 code, the RC clock of at most 500 kHz.
// R2 - In the clock control register bit 7 and bits 3 to 0 read zero, and bits 6 to 4 are writable and clear at reset.
// R3 - With left justification the high result register holds result bits 9 to 2.
// R4 - With left justification the low result register holds result bits 1 and 0 in bits 7 and 6, the rest reserved.
// R5 - With right justification the high result register holds result bits 9 and 8 in bits 1 and 0, the rest reserved.
// R6 - With right justification the low result register holds result bits 7 to 0.
// R7 - Software waits one full acquisition interval after a channel change before it starts a conversion.
// R8 - Software sets the go bit to start a conversion, and the device clears that bit when the conversion is done.
// R9 - At completion both result registers load together in the format selected at that moment.
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH

// Register byte offsets
`define ACS_OFS_CTRL      8'h00
`define ACS_OFS_CLKCTRL   8'h04
`define ACS_OFS_RESHIGH   8'h08
`define ACS_OFS_RESLOW    8'h0C

// Control register fields
`define ACS_CTRL_JUSTIFY  7
`define ACS_CTRL_GO       1
`define ACS_CTRL_ENABLE   0
`define ACS_CTRL_RESET    8'h00

// Clock control register fields
`define ACS_CLK_SEL_HI    6
`define ACS_CLK_SEL_LO    4
`define ACS_CLK_MASK      8'h70
`define ACS_CLK_RESET     3'h0

// Timing
`define ACS_SYS_HZ        10000000
`define ACS_RC_MAX_HZ     500000
`define ACS_RC_DIV        ((`ACS_SYS_HZ + `ACS_RC_MAX_HZ - 1) / `ACS_RC_MAX_HZ)
`define ACS_CONV_TICKS    11

`endif

//--- logic/acs_pkg.sv
// Types shared by the converter control modules.
// Assumes acs_defines.svh supplies the numbers.
`default_nettype none
package acs_pkg;
	typedef logic [2:0] acs_clk_sel_t;
	typedef logic [9:0] acs_result_t;
	typedef enum logic {ACS_JUSTIFY_LEFT, ACS_JUSTIFY_RIGHT} acs_justify_t;
	typedef enum {ACS_IDLE, ACS_CONV} acs_state_t;
endpackage
`default_nettype wire

//--- logic/acs_clk_if.sv
// Carrier between the control top and its conversion clock divider.
// Assumes both ends run on sys_clk.
`timescale 1ns/1ps
`default_nettype none
interface acs_clk_if;
	acs_pkg::acs_clk_sel_t convClockSel;
	logic                  divRun;
	logic                  convTick;
	modport ctrl (output convClockSel, output divRun, input convTick);
	modport div  (input convClockSel, input divRun, output convTick);
endinterface
`default_nettype wire

//--- logic/acs_clock_div.sv
// Conversion clock divider: one-cycle enable pulse at the selected converter rate.
// Assumes sys_clk at 10 MHz; the RC clock is modelled as an enable no faster than 500 kHz.
`timescale 1ns/1ps
`default_nettype none
`include "acs_defines.svh"
module acs_clock_div (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rstn,
	// Control side
	acs_clk_if.div    clk
);
	logic [5:0] cntReg;
	logic [5:0] cntNext;
	logic       tickNext;
	logic       tickReg;

	// Last count (division ratio minus one) for each select code
	function automatic logic [5:0] divLast(input acs_pkg::acs_clk_sel_t sel);
		case (sel)
			3'h0:    divLast = 6'h01;                     // R1
			3'h1:    divLast = 6'h07;                     // R1
			3'h2:    divLast = 6'h1F;                     // R1
			3'h4:    divLast = 6'h03;                     // R1
			3'h5:    divLast = 6'h0F;                     // R1
			3'h6:    divLast = 6'h3F;                     // R1
			default: divLast = 6'(`ACS_RC_DIV - 1);       // R1
		endcase
	endfunction

	// Count sys_clk cycles and pulse at the end of each period
	always_comb begin
		cntNext  = cntReg + 6'h01;
		tickNext = 1'b0;
		if (!clk.divRun) begin
			cntNext = 6'h00;
		end else if (cntReg >= divLast(clk.convClockSel)) begin
			cntNext  = 6'h00;
			tickNext = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cntReg  <= 6'h00;
			tickReg <= 1'b0;
		end else begin
			cntReg  <= cntNext;
			tickReg <= tickNext;
		end
	end

	assign clk.convTick = tickReg;
endmodule
`default_nettype wire

//--- logic/acs_top.sv
// Converter control: AHB-Lite registers, clock select, go/done sequencing and result packing.
// Assumes one AHB-Lite master and an analog front end whose result arrives asynchronously.
// Assumes the front end keeps its result word steady while the hold output is high.
//
// Design decisions made here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "acs_defines.svh"
module acs_top (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [7:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Analog front end
	input  wire logic [9:0]  convResultIn,
	output logic             holdCapacitorHold,
	output logic             convClockTick,
	output logic             convEnabled
);
	acs_clk_if clkBus ();

	acs_clock_div uDiv (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.clk     (clkBus.div)
	);

	// Register state
	logic                   justifyReg, justifyNext;
	logic                   goReg, goNext;
	logic                   enableReg, enableNext;
	acs_pkg::acs_clk_sel_t  clkSelReg, clkSelNext;
	logic [7:0]             resHighReg, resHighNext;
	logic [7:0]             resLowReg, resLowNext;
	// Bus state
	logic                   wrPendReg, wrPendNext;
	logic [7:0]             wrAddrReg, wrAddrNext;
	logic [31:0]            rdataReg, rdataNext;
	// Conversion state
	acs_pkg::acs_state_t    stateReg, stateNext;
	logic [3:0]             tickCntReg, tickCntNext;
	logic                   doneNext;
	logic                   holdReg, holdNext;
	// Analog input synchroniser
	logic [9:0]             resSync1Reg, resSync2Reg;

	logic                   addrPhase;
	logic [7:0]             wByte;
	logic [15:0]            packed16;

	// Two-flop capture of the asynchronous analog result.
	// A moving 10-bit word could tear across the flops; the front end holds it steady
	// for the whole conversion, and only the word two cycles before completion is used.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			resSync1Reg <= 10'h000;
			resSync2Reg <= 10'h000;
		end else begin
			resSync1Reg <= convResultIn;
			resSync2Reg <= resSync1Reg;
		end
	end

	// Pack a result into high and low bytes by justification
	function automatic logic [15:0] packResult(input acs_pkg::acs_result_t r, input logic just);
		if (just == acs_pkg::ACS_JUSTIFY_RIGHT)
			packResult = {6'h00, r[9:8], r[7:0]};         // R5 R6
		else
			packResult = {r[9:2], r[1:0], 6'h00};         // R3 R4
	endfunction

	// Read mux of the register map.
	// It looks at the next-state values, so a read whose address phase meets the data
	// phase of a write sees the written value, as the bus order demands.
	function automatic logic [31:0] readReg(input logic [7:0] a);
		case (a)
			`ACS_OFS_CTRL:    readReg = {24'h000000, justifyNext, 5'h00, goNext, enableNext};
			`ACS_OFS_CLKCTRL: readReg = {24'h000000, 1'b0, clkSelNext, 4'h0};   // R2
			`ACS_OFS_RESHIGH: readReg = {24'h000000, resHighNext};
			`ACS_OFS_RESLOW:  readReg = {24'h000000, resLowNext};
			default:          readReg = 32'h00000000;
		endcase
	endfunction

	assign addrPhase = hsel && htrans[1] && hready;
	assign wByte     = hwdata[7:0];
	assign packed16  = packResult(resSync2Reg, justifyReg);

	// Conversion sequencing on converter clock ticks.
	// A conversion lasts a fixed number of ticks; the first tick may come early because
	// the divider runs whenever the converter is enabled. Clearing enable aborts at once.
	always_comb begin
		stateNext   = stateReg;
		tickCntNext = tickCntReg;
		doneNext    = 1'b0;
		case (stateReg)
			acs_pkg::ACS_IDLE: begin
				tickCntNext = 4'h0;
				if (goReg && enableReg)
					stateNext = acs_pkg::ACS_CONV;          // R8
			end
			acs_pkg::ACS_CONV: begin
				if (!enableReg) begin
					stateNext = acs_pkg::ACS_IDLE;
				end else if (clkBus.convTick) begin
					if (tickCntReg == 4'(`ACS_CONV_TICKS - 1)) begin
						stateNext = acs_pkg::ACS_IDLE;
						doneNext  = 1'b1;                    // R8
					end else begin
						tickCntNext = tickCntReg + 4'h1;
					end
				end
			end
			default: stateNext = acs_pkg::ACS_IDLE;
		endcase
		holdNext = (stateNext == acs_pkg::ACS_CONV);   // R8
	end

	// Bus pipeline: read data is fetched in the address phase
	// The slave never stretches a transfer, so hreadyout is tied high below.
	always_comb begin
		wrPendNext = addrPhase && hwrite;
		wrAddrNext = addrPhase ? haddr : wrAddrReg;
		rdataNext  = (addrPhase && !hwrite) ? readReg(haddr) : rdataReg;
	end

	// Register updates from software writes and conversion completion
	// Completion wins over a software write to a result register in the same cycle.
	always_comb begin
		justifyNext = justifyReg;
		goNext      = goReg;
		enableNext  = enableReg;
		clkSelNext  = clkSelReg;
		resHighNext = resHighReg;
		resLowNext  = resLowReg;
		if (wrPendReg) begin
			case (wrAddrReg)
				`ACS_OFS_CTRL: begin
					justifyNext = wByte[`ACS_CTRL_JUSTIFY];
					enableNext  = wByte[`ACS_CTRL_ENABLE];
					goNext      = goReg | wByte[`ACS_CTRL_GO];   // R8
				end
				`ACS_OFS_CLKCTRL: clkSelNext = wByte[`ACS_CLK_SEL_HI:`ACS_CLK_SEL_LO];   // R2
				`ACS_OFS_RESHIGH: resHighNext = wByte;
				`ACS_OFS_RESLOW:  resLowNext  = wByte;
				default: ;
			endcase
		end
		if (!enableNext)
			goNext = 1'b0;
		if (doneNext) begin
			goNext      = 1'b0;                          // R8
			resHighNext = packed16[15:8];                // R9
			resLowNext  = packed16[7:0];                 // R9
		end
	end

	// Software-visible registers
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			justifyReg <= 1'b0;
			goReg      <= 1'b0;
			enableReg  <= 1'b0;
			clkSelReg  <= `ACS_CLK_RESET;                // R2
			resHighReg <= 8'h00;
			resLowReg  <= 8'h00;
		end else begin
			justifyReg <= justifyNext;
			goReg      <= goNext;
			enableReg  <= enableNext;
			clkSelReg  <= clkSelNext;
			resHighReg <= resHighNext;
			resLowReg  <= resLowNext;
		end
	end

	// Bus pipeline registers
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			wrPendReg  <= 1'b0;
			wrAddrReg  <= 8'h00;
			rdataReg   <= 32'h00000000;
		end else begin
			wrPendReg  <= wrPendNext;
			wrAddrReg  <= wrAddrNext;
			rdataReg   <= rdataNext;
		end
	end

	// Conversion state registers
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			stateReg   <= acs_pkg::ACS_IDLE;
			tickCntReg <= 4'h0;
			holdReg    <= 1'b0;
		end else begin
			stateReg   <= stateNext;
			tickCntReg <= tickCntNext;
			holdReg    <= holdNext;
		end
	end

	// Divider control and outputs
	assign clkBus.convClockSel = clkSelReg;          // R1
	assign clkBus.divRun       = enableReg;
	assign hrdata              = rdataReg;
	assign hreadyout           = 1'b1;
	assign hresp               = 1'b0;
	assign holdCapacitorHold   = holdReg;                     // R8
	assign convClockTick       = clkBus.convTick;
	assign convEnabled         = enableReg;
endmodule
`default_nettype wire

//--- verif/acs_chk.sv
// Checker for the converter control ports: bus answers, tick spacing and hold window.
// Bound onto acs_top; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module acs_chk (
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        rstn,
	// Bus
	input wire logic        hsel,
	input wire logic [7:0]  haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	// Front end
	input wire logic        holdCapacitorHold,
	input wire logic        convClockTick,
	input wire logic        convEnabled
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	logic       rdPh, rdClk;
	logic [7:0] gap;
	// Read data phases and cycles since the last tick
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rdPh  <= 1'b0;
			rdClk <= 1'b0;
			gap   <= 8'h00;
		end else begin
			rdPh  <= hsel && htrans[1] && hready && !hwrite;
			rdClk <= haddr == 8'h04;
			gap   <= (convClockTick || !convEnabled) ? 8'h00 : gap + 8'h01;
		end
	end
	sequence convStart;
		$rose(holdCapacitorHold);
	endsequence
	bus_ready_a: assert property (hreadyout) else $error("ready low");
	rd_upper_a: assert property (rdPh |-> hrdata[31:8] == 24'h0) else $error("upper bits");
	clk_unused_a: assert property (rdPh && rdClk |-> hrdata[7] == 1'b0 && hrdata[3:0] == 4'h0)
		else $error("unused clock bits");
	tick_gap_a: assert property (convClockTick |=> !convClockTick) else $error("ticks adjacent");
	tick_slow_a: assert property (gap <= 8'h82) else $error("tick late");
	hold_min_a: assert property (convStart |-> holdCapacitorHold[*8]) else $error("hold short");
	hold_end_a: assert property (convStart |-> ##[1:1000] !holdCapacitorHold) else $error("hold stuck");
	hold_en_a: assert property (convStart |-> convEnabled) else $error("hold while off");
endmodule
bind acs_top acs_chk i_chk (.sys_clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout,
	.holdCapacitorHold, .convClockTick, .convEnabled);
`default_nettype wire

//--- verif/acs_front_model.sv
// Analog source model: a steady level while held, a changing pattern otherwise.
// Assumes the bench sets the level before a conversion starts.
`timescale 1ns/1ps
`default_nettype none
module acs_front_model (
	// Clock
	input wire logic       sys_clk,
	// Bench and device
	input wire logic [9:0] level,
	input wire logic       holdCapacitorHold,
	output var logic [9:0] convResultIn = 10'h155
);
	// Level only while the sample is held
	always_ff @(posedge sys_clk) begin
		convResultIn <= holdCapacitorHold ? level : ~convResultIn;
	end
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// Bench: registers over AHB-Lite, converter clock rates, result packing.
// Assumes the front end model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "acs_defines.svh"
module tb_top;
	logic        sys_clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, dPh = 1'b0;
	logic [7:0]  haddr = 8'h00;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0, hrdata, rdat;
	logic        hready, hreadyout, hresp, holdCapacitorHold, convClockTick, convEnabled;
	logic [9:0]  convResultIn, level = 10'h000;
	logic [32:0] note, expQ[$];
	int          num_errors = 0, checks_done = 0;
	int          per[8] = '{2, 8, 32, `ACS_RC_DIV, 4, 16, 64, `ACS_RC_DIV};
	always #50 sys_clk = ~sys_clk;
	assign hready = hreadyout;
	acs_top i_dut (.sys_clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata, .hrdata,
		.hreadyout, .hresp, .convResultIn, .holdCapacitorHold, .convClockTick, .convEnabled);
	acs_front_model i_src (.sys_clk, .level, .holdCapacitorHold, .convResultIn);
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic stop_test;
		$display("TB: checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Bounded wait for a level sampled high at a rising edge
	task automatic waitHi(ref logic s, output int n);
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (s !== 1'b1 && n < 200);
		if (n >= 200) begin
			num_errors++;
			stop_test;
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [32:0] e);
		int n;
		if (!w) expQ.push_back(e);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		waitHi(hready, n);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		waitHi(hready, n);
		rdat = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		xfer(1'b1, a, d, 33'h0);
		@(posedge sys_clk);
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		xfer(1'b0, a, 8'h00, {1'b1, 24'h0, e});
	endtask
	// Pop the oldest note at each read data phase and compare it when its top bit is set
	always @(posedge sys_clk) begin
		if (dPh) begin
			note = expQ.pop_front();
			if (note[32]) chk("rdata", note[31:0], hrdata);
		end
		dPh <= hsel && htrans[1] && !hwrite;
	end
	initial begin
		logic [7:0] d;
		logic [9:0] v;
		int         g;
		d = 8'($urandom(32'hAE6D));
		repeat (2) @(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		rc(8'h04, 8'h00);
		wr(8'h04, d);
		rc(8'h04, d & 8'h70);
		rc(8'h10, 8'h00);
		wr(8'h08, ~d);
		rc(8'h08, ~d);
		wr(8'h0C, d);
		rc(8'h0C, d);
		$display("TB: regs done");
		for (int s = 0; s < 8; s++) begin
			wr(8'h04, {1'b0, 3'(s), 4'h0});
			wr(8'h00, 8'h01);
			waitHi(convClockTick, g);
			waitHi(convClockTick, g);
			chk("tick gap", per[s], g);
		end
		$display("TB: clock done");
		wr(8'h04, 8'h00);
		// Justification set while converting; it counts at completion
		for (int j = 0; j < 2; j++) begin
			v = 10'($urandom);
			level <= v;
			repeat (8) @(posedge sys_clk);
			wr(8'h00, 8'h03);
			wr(8'h00, {j[0], 7'h03});
			rc(8'h00, {j[0], 7'h03});
			g = 0;
			do begin
				xfer(1'b0, 8'h00, 8'h00, 33'h0);
				g++;
			end while (rdat[1] !== 1'b0 && g < 99);
			chk("done", 32'h0, {31'h0, rdat[1]});
			rc(8'h08, j ? {6'h00, v[9:8]} : v[9:2]);
			rc(8'h0C, j ? v[7:0] : {v[1:0], 6'h00});
		end
		// Abort by clearing enable leaves the results alone
		level <= ~v;
		repeat (8) @(posedge sys_clk);
		wr(8'h00, 8'h03);
		rc(8'h00, 8'h03);
		repeat (6) @(posedge sys_clk);
		wr(8'h00, 8'h00);
		rc(8'h00, 8'h00);
		rc(8'h08, {6'h00, v[9:8]});
		rc(8'h0C, v[7:0]);
		$display("TB: convert done");
		// Reset in mid-run returns the clock select to zero
		wr(8'h04, 8'h60);
		rstn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		rc(8'h04, 8'h00);
		rc(8'h00, 8'h00);
		$display("TB: reset done");
		stop_test;
	end
endmodule
`default_nettype wire
